// [core/lpl_pkg.sv]
// constants for the pixel link serialiser and deserialiser
// Function
// - transmitter takes 28-bit word each pixel clock while ready is high
// - falling select captures on shift clock fall
// - select high rising, low or open falling
// - transmitter sleep floats all serial outputs
// - seven bits per lane per cycle
// - four data lanes plus forwarded clock lane
// - receiver outputs word in same bit positions
// - receiver pixel clock falling edge strobes data
// - receiver sleep forces parallel outputs low
package lpl_pkg;
  localparam int WORD_W = 28;
  localparam int LANES = 4;
  localparam int SLOTS = 7;
  localparam int COLOR_W = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int RED_LSB = 0;
  localparam int GREEN_LSB = 8;
  localparam int BLUE_LSB = 16;
  localparam int LINE_SYNC_BIT = 24;
  localparam int FRAME_SYNC_BIT = 25;
  localparam int PIXEL_VALID_BIT = 26;
  localparam int SPARE_BIT = 27;
  // slot s of the clock lane is bit s: high 0-1, low 2-4, high 5-6
  localparam logic [6:0] CLK_LANE_PAT = 7'h63;
  localparam logic [2:0] FIRST_SLOT = 3'h0;
  localparam logic [2:0] LAST_SLOT = 3'h6;
  localparam logic [2:0] RX_CLK_HIGH = 3'h4;
endpackage : lpl_pkg

// [core/lpl_serdes.sv]
// pixel link transmitter and receiver pair with its crossing fifo
`timescale 1ns/100ps

module lpl_fifo #(
  parameter int WIDTH = 28,
  parameter int DEPTH = 8
) (
  // write side
  input wire logic wr_clk_i,
  input wire logic wr_rst_i,
  input wire logic wr_valid_i,
  input wire logic [WIDTH-1:0] wr_data_i,
  output logic wr_ready_o,
  // read side
  input wire logic rd_clk_i,
  input wire logic rd_rst_i,
  output logic rd_valid_o,
  output logic [WIDTH-1:0] rd_data_o,
  input wire logic rd_ready_i
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] bin;
    logic [AW:0] gray;
    logic [AW:0] far_s1;
    logic [AW:0] far_s2;
  } lpl_side_t;

  if (DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_bad_depth
    $error("fifo depth must be a power of two, four or more");
  end

  function automatic logic [AW:0] to_gray(input logic [AW:0] b);
    to_gray = b ^ (b >> 1);
  endfunction : to_gray

  logic [WIDTH-1:0] mem [DEPTH];
  lpl_side_t wr;
  lpl_side_t next_wr;
  lpl_side_t rd;
  lpl_side_t next_rd;
  logic push;
  logic pop;

  // pointers cross as gray code so a torn sample is off by one at most
  assign wr_ready_o = wr.gray != {~wr.far_s2[AW:AW-1], wr.far_s2[AW-2:0]};
  assign rd_valid_o = rd.gray != rd.far_s2;
  assign rd_data_o = mem[rd.bin[AW-1:0]];
  assign push = wr_valid_i && wr_ready_o;
  assign pop = rd_valid_o && rd_ready_i;

  always_comb
  begin
    next_wr = wr;
    next_wr.far_s1 = rd.gray;
    next_wr.far_s2 = wr.far_s1;
    if (push)
    begin
      next_wr.bin = wr.bin + 1'b1;
      next_wr.gray = to_gray(next_wr.bin);
    end
    next_rd = rd;
    next_rd.far_s1 = wr.gray;
    next_rd.far_s2 = rd.far_s1;
    if (pop)
    begin
      next_rd.bin = rd.bin + 1'b1;
      next_rd.gray = to_gray(next_rd.bin);
    end
  end

  always_ff @(posedge wr_clk_i)
  begin
    if (wr_rst_i)
      wr <= '0;
    else
      wr <= next_wr;
    if (push && !wr_rst_i)
      mem[wr.bin[AW-1:0]] <= wr_data_i;
  end

  always_ff @(posedge rd_clk_i)
  begin
    if (rd_rst_i)
      rd <= '0;
    else
      rd <= next_rd;
  end
endmodule : lpl_fifo

module lpl_serdes #(
  parameter int FIFO_DEPTH = lpl_pkg::FIFO_DEPTH
) (
  // core clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  // transmitter parallel side, pixel shift clock domain
  input wire logic PIX_SHIFT_CLK_I,
  input wire logic [7:0] TX_RED_I,
  input wire logic [7:0] TX_GREEN_I,
  input wire logic [7:0] TX_BLUE_I,
  input wire logic TX_LINE_SYNC_I,
  input wire logic TX_FRAME_SYNC_I,
  input wire logic TX_PIXEL_VALID_I,
  input wire logic TX_SPARE_I,
  input wire logic TX_STROBE_EDGE_SELECT_I,
  input wire logic TX_SLEEP_N_I,
  output logic TX_PIXEL_READY_O,
  // transmitter serial side
  output logic [3:0] SERIAL_LANE_OUT_O,
  output logic [3:0] SERIAL_LANE_OE_N_O,
  output logic FORWARDED_LINK_CLOCK_OUT_O,
  output logic FORWARDED_LINK_CLOCK_OE_N_O,
  // receiver serial side
  input wire logic [3:0] SERIAL_LANE_IN_I,
  input wire logic FORWARDED_LINK_CLOCK_IN_I,
  input wire logic RX_SLEEP_N_I,
  // receiver parallel side
  output logic [7:0] RX_RED_O,
  output logic [7:0] RX_GREEN_O,
  output logic [7:0] RX_BLUE_O,
  output logic RX_LINE_SYNC_O,
  output logic RX_FRAME_SYNC_O,
  output logic RX_PIXEL_VALID_O,
  output logic RX_SPARE_O,
  output logic RX_PIXEL_CLOCK_OUT_O
);
  localparam int W = lpl_pkg::WORD_W;
  localparam int N = lpl_pkg::SLOTS;

  if (lpl_pkg::LANES * N != W)
  begin : g_bad_split
    $error("lanes times slots must equal the word width");
  end

  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic sel_s1;
    logic sel_s2;
    logic slp_s1;
    logic slp_s2;
  } lpl_pix_t;

  typedef struct packed {
    logic tx_slp_s1;
    logic tx_slp_s2;
    logic rx_slp_s1;
    logic rx_slp_s2;
    logic [3:0] rx_lane_s1;
    logic [3:0] rx_lane_s2;
    logic rx_clk_s1;
    logic rx_clk_s2;
    logic [2:0] slot;
    logic [27:0] word;
    logic [3:0] lane_out;
    logic clk_out;
    logic oe_n;
    logic [3:0][6:0] sr_lane;
    logic [6:0] sr_clk;
    logic [27:0] rx_word;
    logic [2:0] rx_phase;
    logic rx_clk;
  } lpl_core_t;

  function automatic logic lane_bit(input logic [27:0] w, input int l,
                                    input logic [2:0] s);
    lane_bit = w[l * N + int'(s)];
  endfunction : lane_bit

  lpl_pix_t pix;
  lpl_pix_t next_pix;
  lpl_core_t st;
  lpl_core_t next_st;
  logic [W-1:0] tx_in_word;
  logic [W-1:0] fall_word;
  logic [W-1:0] wr_data;
  logic wr_valid;
  logic [W-1:0] rd_data;
  logic rd_valid;
  logic rd_ready;
  logic rx_match;
  logic tx_bit3;

  assign tx_in_word = {TX_SPARE_I, TX_PIXEL_VALID_I, TX_FRAME_SYNC_I,
                       TX_LINE_SYNC_I, TX_BLUE_I, TX_GREEN_I, TX_RED_I};

  // pixel shift clock domain: straps, sleep and reset all pass two flops
  always_comb
  begin
    next_pix = pix;
    next_pix.rst_s1 = RST_I;
    next_pix.rst_s2 = pix.rst_s1;
    next_pix.sel_s1 = TX_STROBE_EDGE_SELECT_I;
    next_pix.sel_s2 = pix.sel_s1;
    next_pix.slp_s1 = TX_SLEEP_N_I;
    next_pix.slp_s2 = pix.slp_s1;
  end

  always_ff @(posedge PIX_SHIFT_CLK_I)
  begin
    pix <= next_pix;
  end

  // data only, so no reset: caught on the fall, handed on at the next rise
  always_ff @(negedge PIX_SHIFT_CLK_I)
  begin
    fall_word <= tx_in_word;
  end

  // select low or unconnected means falling capture
  assign wr_data = pix.sel_s2 ? tx_in_word : fall_word;
  assign wr_valid = pix.slp_s2 && !pix.rst_s2;

  // the core drains one word per seven cycles, slower than the pixel
  // rate; the ready output lets the source pace itself
  lpl_fifo #(
    .WIDTH(W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .wr_clk_i(PIX_SHIFT_CLK_I),
    .wr_rst_i(pix.rst_s2),
    .wr_valid_i(wr_valid),
    .wr_data_i(wr_data),
    .wr_ready_o(TX_PIXEL_READY_O),
    .rd_clk_i(CORE_CLK_I),
    .rd_rst_i(RST_I),
    .rd_valid_o(rd_valid),
    .rd_data_o(rd_data),
    .rd_ready_i(rd_ready)
  );

  assign rd_ready = st.tx_slp_s2 && st.slot == lpl_pkg::LAST_SLOT;
  assign rx_match = st.sr_clk == lpl_pkg::CLK_LANE_PAT;
  assign tx_bit3 = lane_bit(st.word, 3, st.slot);

  always_comb
  begin
    next_st = st;
    next_st.tx_slp_s1 = TX_SLEEP_N_I;
    next_st.tx_slp_s2 = st.tx_slp_s1;
    next_st.rx_slp_s1 = RX_SLEEP_N_I;
    next_st.rx_slp_s2 = st.rx_slp_s1;
    next_st.rx_lane_s1 = SERIAL_LANE_IN_I;
    next_st.rx_lane_s2 = st.rx_lane_s1;
    next_st.rx_clk_s1 = FORWARDED_LINK_CLOCK_IN_I;
    next_st.rx_clk_s2 = st.rx_clk_s1;
    // transmit
    if (!st.tx_slp_s2)
    begin
      next_st.slot = lpl_pkg::FIRST_SLOT;
      next_st.word = '0;
      next_st.lane_out = '0;
      next_st.clk_out = 1'b0;
      next_st.oe_n = 1'b1;
    end
    else
    begin
      next_st.oe_n = 1'b0;
      next_st.clk_out = lpl_pkg::CLK_LANE_PAT[st.slot];
      for (int l = 0; l < lpl_pkg::LANES; l++)
      begin
        next_st.lane_out[l] = lane_bit(st.word, l, st.slot);
      end
      if (st.slot == lpl_pkg::LAST_SLOT)
      begin
        next_st.slot = lpl_pkg::FIRST_SLOT;
        // an empty fifo sends a blank word with pixel valid low
        next_st.word = rd_valid ? rd_data : '0;
      end
      else
      begin
        next_st.slot = st.slot + 3'h1;
      end
    end
    // receive: bits enter at the top so slot s ends at index s
    next_st.sr_clk = {st.rx_clk_s2, st.sr_clk[N-1:1]};
    for (int l = 0; l < lpl_pkg::LANES; l++)
    begin
      next_st.sr_lane[l] = {st.rx_lane_s2[l], st.sr_lane[l][N-1:1]};
    end
    if (!st.rx_slp_s2)
    begin
      next_st.rx_word = '0;
      next_st.rx_clk = 1'b0;
      next_st.rx_phase = lpl_pkg::LAST_SLOT;
    end
    else if (rx_match)
    begin
      for (int l = 0; l < lpl_pkg::LANES; l++)
      begin
        for (int s = 0; s < N; s++)
        begin
          next_st.rx_word[l * N + s] = st.sr_lane[l][s];
        end
      end
      next_st.rx_phase = lpl_pkg::FIRST_SLOT;
      next_st.rx_clk = 1'b1;
    end
    else
    begin
      if (st.rx_phase != lpl_pkg::LAST_SLOT)
      begin
        next_st.rx_phase = st.rx_phase + 3'h1;
      end
      // word changes on the rise, so the fall sees it settled
      next_st.rx_clk = (st.rx_phase + 3'h1) < lpl_pkg::RX_CLK_HIGH;
    end
  end

  always_ff @(posedge CORE_CLK_I)
  begin
    if (RST_I)
    begin
      st <= '0;
      st.oe_n <= 1'b1;
      st.rx_phase <= lpl_pkg::LAST_SLOT;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign SERIAL_LANE_OUT_O = st.lane_out;
  assign SERIAL_LANE_OE_N_O = {lpl_pkg::LANES{st.oe_n}};
  assign FORWARDED_LINK_CLOCK_OUT_O = st.clk_out;
  assign FORWARDED_LINK_CLOCK_OE_N_O = st.oe_n;
  assign RX_RED_O = st.rx_word[lpl_pkg::RED_LSB +: lpl_pkg::COLOR_W];
  assign RX_GREEN_O = st.rx_word[lpl_pkg::GREEN_LSB +: lpl_pkg::COLOR_W];
  assign RX_BLUE_O = st.rx_word[lpl_pkg::BLUE_LSB +: lpl_pkg::COLOR_W];
  assign RX_LINE_SYNC_O = st.rx_word[lpl_pkg::LINE_SYNC_BIT];
  assign RX_FRAME_SYNC_O = st.rx_word[lpl_pkg::FRAME_SYNC_BIT];
  assign RX_PIXEL_VALID_O = st.rx_word[lpl_pkg::PIXEL_VALID_BIT];
  assign RX_SPARE_O = st.rx_word[lpl_pkg::SPARE_BIT];
  assign RX_PIXEL_CLOCK_OUT_O = st.rx_clk;

  sequence clk_lane_tail;
    FORWARDED_LINK_CLOCK_OUT_O ##1 !FORWARDED_LINK_CLOCK_OUT_O [*3];
  endsequence

  sequence tx_awake_at_slot1;
    (st.slot == 3'h1 && st.tx_slp_s2) ##1 st.tx_slp_s2;
  endsequence

  chk_clk_lane_shape: assert property (
    @(posedge CORE_CLK_I) disable iff (RST_I)
    tx_awake_at_slot1 |-> clk_lane_tail)
    else $error("clock lane pattern wrong");

  chk_tx_sleep_float: assert property (
    @(posedge CORE_CLK_I) disable iff (RST_I)
    !st.tx_slp_s2 |=> (&SERIAL_LANE_OE_N_O && FORWARDED_LINK_CLOCK_OE_N_O))
    else $error("serial outputs driven while asleep");

  chk_lane_bit_order: assert property (
    @(posedge CORE_CLK_I) disable iff (RST_I)
    st.tx_slp_s2 |=> SERIAL_LANE_OUT_O[3] == $past(tx_bit3))
    else $error("lane bit does not follow word and slot");

  chk_slot_wrap: assert property (
    @(posedge CORE_CLK_I) disable iff (RST_I)
    (st.slot == 3'h6 && st.tx_slp_s2) |=> (st.slot == 3'h0
    ##6 (st.slot == 3'h6 || !st.tx_slp_s2)) or !st.tx_slp_s2 [*1])
    else $error("slot counter does not wrap after seven");

  chk_tx_word_load: assert property (
    @(posedge CORE_CLK_I) disable iff (RST_I)
    (rd_ready && rd_valid) |=> st.word == $past(rd_data))
    else $error("fifo word not loaded at period start");

  chk_rx_word_place: assert property (
    @(posedge CORE_CLK_I) disable iff (RST_I)
    (rx_match && st.rx_slp_s2) |=> (st.rx_word[6:0] == $past(st.sr_lane[0])
    && st.rx_word[27:21] == $past(st.sr_lane[3]) && RX_PIXEL_CLOCK_OUT_O))
    else $error("recovered word misplaced");

  chk_rx_strobe_fall: assert property (
    @(posedge CORE_CLK_I) disable iff (RST_I)
    $fell(RX_PIXEL_CLOCK_OUT_O) |-> ($stable(st.rx_word)
    && $past(st.rx_phase) == 3'h3 || $past(st.rx_slp_s2) == 1'b0))
    else $error("pixel clock fell at wrong phase or over a data change");

  chk_rx_sleep_low: assert property (
    @(posedge CORE_CLK_I) disable iff (RST_I)
    !st.rx_slp_s2 |=> (st.rx_word == '0 && !RX_PIXEL_CLOCK_OUT_O))
    else $error("receiver outputs not low while asleep");

  // falling mode: the word pushed is the one present at the last fall
  chk_edge_capture: assert property (
    @(negedge PIX_SHIFT_CLK_I) disable iff (pix.rst_s2)
    !pix.sel_s2 |=> (pix.sel_s2 || wr_data == $past(tx_in_word)))
    else $error("captured word from the wrong edge");
endmodule : lpl_serdes

// [tb/lpl_link_model.sv]
// cable model joining the serial outputs back to the serial inputs
`timescale 1ns/100ps
module lpl_link_model (
  // core clock
  input wire logic clk_i,
  // transmitter side
  input wire logic [3:0] lane_i,
  input wire logic [3:0] lane_oe_n_i,
  input wire logic lclk_i,
  input wire logic lclk_oe_n_i,
  // receiver side
  output logic [3:0] lane_o,
  output logic lclk_o
);
  logic [4:0] flip = 5'h00;
  // released lines flip each cycle so no stale level looks valid
  always @(posedge clk_i)
    flip <= ~flip;
  always_comb
  begin
    for (int l = 0; l < 4; l++)
      lane_o[l] = lane_oe_n_i[l] ? flip[l] : lane_i[l];
    lclk_o = lclk_oe_n_i ? flip[4] : lclk_i;
  end
endmodule : lpl_link_model

// [tb/lpl_serdes_tb.sv]
// self-checking bench for the pixel link serdes
`timescale 1ns/100ps
module lpl_serdes_tb;
  logic clk = 1'b0;
  logic pclk = 1'b0;
  logic rst = 1'b1;
  logic sel = 1'b1;
  logic tx_sleep_n = 1'b1;
  logic rx_sleep_n = 1'b1;
  logic saw_full = 1'b0;
  logic [27:0] tx_word = 28'h0;
  logic ready, lclk_out, lclk_oe_n, lclk_in, rx_clk;
  logic [3:0] lane_out, lane_oe_n, lane_in;
  wire [27:0] rx_word;
  logic [27:0] exp_q[$], wire_q[$], rx_q[$];
  logic [6:0] clk_h = 7'h00;
  logic [6:0] lane_h [4];
  int gap = 100;
  int error_cnt = 0;
  int checks = 0;

  always #12.5 clk = ~clk;
  initial
  begin
    #7;
    forever #32 pclk = ~pclk;
  end

  lpl_serdes #(.FIFO_DEPTH(lpl_pkg::FIFO_DEPTH)) dut (
    .CORE_CLK_I(clk), .RST_I(rst), .PIX_SHIFT_CLK_I(pclk),
    .TX_RED_I(tx_word[7:0]), .TX_GREEN_I(tx_word[15:8]),
    .TX_BLUE_I(tx_word[23:16]), .TX_LINE_SYNC_I(tx_word[24]),
    .TX_FRAME_SYNC_I(tx_word[25]), .TX_PIXEL_VALID_I(tx_word[26]),
    .TX_SPARE_I(tx_word[27]), .TX_STROBE_EDGE_SELECT_I(sel),
    .TX_SLEEP_N_I(tx_sleep_n), .TX_PIXEL_READY_O(ready),
    .SERIAL_LANE_OUT_O(lane_out), .SERIAL_LANE_OE_N_O(lane_oe_n),
    .FORWARDED_LINK_CLOCK_OUT_O(lclk_out),
    .FORWARDED_LINK_CLOCK_OE_N_O(lclk_oe_n),
    .SERIAL_LANE_IN_I(lane_in), .FORWARDED_LINK_CLOCK_IN_I(lclk_in),
    .RX_SLEEP_N_I(rx_sleep_n), .RX_RED_O(rx_word[7:0]),
    .RX_GREEN_O(rx_word[15:8]), .RX_BLUE_O(rx_word[23:16]),
    .RX_LINE_SYNC_O(rx_word[24]), .RX_FRAME_SYNC_O(rx_word[25]),
    .RX_PIXEL_VALID_O(rx_word[26]), .RX_SPARE_O(rx_word[27]),
    .RX_PIXEL_CLOCK_OUT_O(rx_clk));

  lpl_link_model link (.clk_i(clk), .lane_i(lane_out),
    .lane_oe_n_i(lane_oe_n), .lclk_i(lclk_out), .lclk_oe_n_i(lclk_oe_n),
    .lane_o(lane_in), .lclk_o(lclk_in));

  // words seen on the wire, framed by the clock lane alone
  always @(negedge clk)
  begin
    logic [27:0] w;
    clk_h = {lclk_out, clk_h[6:1]};
    for (int l = 0; l < 4; l++)
      lane_h[l] = {lane_out[l], lane_h[l][6:1]};
    gap++;
    if (!lclk_oe_n && clk_h == lpl_pkg::CLK_LANE_PAT)
    begin
      for (int b = 0; b < 28; b++)
        w[b] = lane_h[b / 7][b % 7];
      if (w[lpl_pkg::PIXEL_VALID_BIT])
        wire_q.push_back(w);
      // restart after sleep or reset is not a period
      if (gap != 7 && gap < 20)
        bad("clock lane period");
      gap = 0;
    end
  end

  always @(negedge rx_clk)
    if (rx_word[lpl_pkg::PIXEL_VALID_BIT] === 1'b1)
      rx_q.push_back(rx_word);

  task automatic print_verdict();
    if (error_cnt == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : print_verdict

  task automatic bad(input string m);
    error_cnt++;
    $display("unexpected at %0t: %s", $time, m);
  endtask : bad

  task automatic cmp_word(input logic [27:0] got, input logic [27:0] exp);
    checks++;
    if (got !== exp)
      bad($sformatf("word %h, want %h", got, exp));
  endtask : cmp_word

  task automatic cmp_bit(input logic got, input logic exp, input string m);
    checks++;
    if (got !== exp)
      bad(m);
  endtask : cmp_bit

  function automatic logic [27:0] mk(input int i);
    return (28'h0a5c3e1 * i[27:0]) | 28'h4000000;
  endfunction : mk

  // early word stands at the falling edge, late one at the rising edge
  task automatic send_word(input logic [27:0] early, input logic [27:0] late);
    int n;
    logic r;
    for (n = 0; n < 200; n++)
    begin
      @(posedge pclk);
      #1 tx_word = early;
      @(negedge pclk);
      r = ready;
      #1 tx_word = late;
      if (r === 1'b1)
        break;
      saw_full = 1'b1;
    end
    if (n == 200)
    begin
      bad("ready stuck low");
      print_verdict();
    end
    exp_q.push_back(sel ? late : early);
    @(posedge pclk);
    #1 tx_word = 28'h0;
  endtask : send_word

  task automatic drain();
    int t;
    for (t = 0; t < 3000 && rx_q.size() < exp_q.size(); t++)
      @(negedge clk);
    if (rx_q.size() < exp_q.size())
    begin
      bad("rx words missing");
      print_verdict();
    end
    cmp_bit(wire_q.size() == exp_q.size(), 1'b1, "wire count");
    cmp_bit(|{lane_oe_n, lclk_oe_n}, 1'b0, "lanes released");
    while (exp_q.size() > 0)
    begin
      if (wire_q.size() > 0)
        cmp_word(wire_q.pop_front(), exp_q[0]);
      cmp_word(rx_q.pop_front(), exp_q.pop_front());
    end
  endtask : drain

  task automatic sc_strobe(input logic s, input int n);
    @(negedge clk) sel = s;
    repeat (10) @(negedge clk);
    saw_full = 1'b0;
    for (int i = 1; i <= n; i++)
      send_word(mk(i + n), mk(i) ^ 28'h0ffffff);
    cmp_bit(saw_full, 1'b1, "fifo never refused");
    drain();
  endtask : sc_strobe

  task automatic sc_tx_sleep();
    @(negedge clk) tx_sleep_n = 1'b0;
    repeat (10) @(negedge clk);
    for (int c = 0; c < 14; c++)
    begin
      @(negedge clk);
      cmp_bit(&{lane_oe_n, lclk_oe_n}, 1'b1, "lanes driven");
      tx_word = 28'h7ffffff;
    end
    tx_word = 28'h0;
    repeat (8) @(negedge clk);
    tx_sleep_n = 1'b1;
    send_word(mk(20), mk(20));
    drain();
  endtask : sc_tx_sleep

  task automatic sc_rx_sleep();
    @(negedge clk) rx_sleep_n = 1'b0;
    send_word(mk(30), mk(30));
    repeat (6) @(negedge clk);
    for (int c = 0; c < 120; c++)
    begin
      @(negedge clk);
      cmp_bit(|{rx_word, rx_clk}, 1'b0, "rx outputs awake");
    end
    rx_sleep_n = 1'b1;
    cmp_bit(wire_q.size() == 1, 1'b1, "wire word lost");
    if (wire_q.size() > 0)
      cmp_word(wire_q.pop_front(), exp_q.pop_front());
    cmp_bit(rx_q.size() == 0, 1'b1, "rx strobed asleep");
    // receiver must pick words up again once awake
    send_word(mk(31), mk(31));
    drain();
  endtask : sc_rx_sleep

  initial
  begin
    // longer than two cycles: pixel side needs three of its own edges
    repeat (8) @(negedge clk);
    rst = 1'b0;
    sc_strobe(1'b1, 12);
    sc_strobe(1'b0, 4);
    sc_tx_sleep();
    sc_rx_sleep();
    print_verdict();
  end
endmodule : lpl_serdes_tb
